// ==== bia_top.sv ====
// Design: two cascaded priority controllers, request filter, NMI gate, spare latch
//
// Overview of operation
// - filter blocks requests shorter than 50 ns
// - long request latched until ack and release
// - filter off by default, request passes through
// - mask bit 1 forces NMI low
// - NMI request is backplane 0 OR parity
// - eight lines, line 0 highest priority
// - optional rotating priority per controller
// - pending register, one bit per line
// - in-service register fed from pending
// - secondary drives primary line 7, fifteen levels
// - spurious reported on line 7
// - secondary identical, output to routing point
// - spare latch turns edge into level
// - backplane drives from port bits, parity
// - writing 0 clears the spare latch
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps

// ****************************************************************
// One eight-line priority controller
// ****************************************************************
module bia_priority_int_ctrl (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] req,
  input  wire logic [7:0] imask,
  input  wire logic       rotate,
  input  wire logic       ack,
  input  wire logic       eoi,
  output logic      [7:0] pend,
  output logic      [7:0] insvc,
  output logic            int_req,
  output logic      [2:0] ack_level,
  output logic            ack_none
);
  logic [7:0] pending_request_reg_ff;
  logic [7:0] in_service_reg_ff;
  logic [2:0] base_ff;
  logic [7:0] cand;
  logic [2:0] idx;
  logic       win_found;
  logic [2:0] win_lvl;
  logic [2:0] win_rank;
  logic       isv_found;
  logic [2:0] isv_lvl;
  logic [2:0] isv_rank;

  assign cand = pending_request_reg_ff & ~imask;

  // Walk from lowest rank up so the best rank is left last
  always_comb begin
    win_found = 1'b0;
    win_lvl   = 3'h7;
    win_rank  = 3'h7;
    isv_found = 1'b0;
    isv_lvl   = 3'h7;
    isv_rank  = 3'h7;
    idx       = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      idx = 3'(base_ff + 3'(i));
      if (cand[idx]) begin
        win_found = 1'b1;
        win_lvl   = idx;
        win_rank  = 3'(i);
      end
      if (in_service_reg_ff[idx]) begin
        isv_found = 1'b1;
        isv_lvl   = idx;
        isv_rank  = 3'(i);
      end
    end
  end

  // Nested: only a better rank than the one in service interrupts
  assign int_req   = win_found && (!isv_found || win_rank < isv_rank);
  assign ack_none  = !win_found;
  assign ack_level = win_found ? win_lvl : 3'h7;
  assign pend      = pending_request_reg_ff;
  assign insvc     = in_service_reg_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_request_reg_ff <= 8'h00;
      in_service_reg_ff      <= 8'h00;
      base_ff                <= 3'h0;
    end else begin
      pending_request_reg_ff <= req;
      // End of service first, so a same-cycle acknowledge still sets its bit
      if (eoi && isv_found) begin
        in_service_reg_ff[isv_lvl] <= 1'b0;
      end
      if (ack && win_found) begin
        in_service_reg_ff[win_lvl]      <= 1'b1;
        pending_request_reg_ff[win_lvl] <= 1'b0;
      end
      if (!rotate) begin
        base_ff <= 3'h0;
      end else if (eoi && isv_found) begin
        base_ff <= 3'(isv_lvl + 3'h1);
      end
    end
  end
endmodule : bia_priority_int_ctrl

// ****************************************************************
// Top level
// ****************************************************************
module bia_top #(
  parameter logic [2:0] CASCADE_LINE = 3'h7
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] pri_req_in,
  input  wire logic [7:0] sec_req_in,
  input  wire logic       cpu_int_ack,
  input  wire logic       backplane_int0,
  input  wire logic       parity_err_pulse,
  input  wire logic       edge_latch_set_in,
  output logic            cpu_int_out,
  output logic            cpu_nmi_out,
  output logic            ack_valid,
  output logic      [3:0] ack_vector,
  output logic            ack_spurious,
  output logic            sec_int_route,
  output logic            edge_latch_out,
  output logic            parity_error_drive_n,
  output logic            backplane_int_drive_one_n,
  output logic            backplane_int_drive_two_n,
  output logic            irq
);
  bia_pkg::bia_ctrl_type ctrl_ff;
  bia_pkg::bia_vec_type  vec_ff;
  logic [7:0]            pri_mask_ff;
  logic [7:0]            sec_mask_ff;
  logic [7:0]            rdata_ff;
  logic [4:0]            stat_ff;
  logic [4:0]            imsk_ff;
  logic                  irq_ff;
  logic                  cpu_int_ff;
  logic                  nmi_ff;
  logic                  ackv_ff;
  logic                  spur_ff;
  logic                  sec_route_ff;
  logic                  edge_ff;
  logic                  edge_in_prev_ff;
  logic                  parity_ff;
  logic                  par_drive_n_ff;
  logic                  filt_latch_ff;
  logic                  ack_seen_ff;
  logic                  raw_prev_ff;
  logic [2:0]            filt_cnt_ff;
  logic                  nmi_prev_ff;

  logic       wr_ctrl;
  logic       wr_eoi;
  logic       wr_par_clr;
  logic       rd_stat;
  logic [7:0] pri_req;
  logic [7:0] pri_pend;
  logic [7:0] pri_insvc;
  logic [7:0] sec_pend;
  logic [7:0] sec_insvc;
  logic       pri_int;
  logic       sec_int;
  logic [2:0] pri_lvl;
  logic [2:0] sec_lvl;
  logic       pri_none;
  logic       sec_none;
  logic       sec_ack;
  logic       raw_cpu_int_request;
  logic       nonmaskable_request_in;
  logic       nxt_nmi;
  logic [2:0] nxt_filt_cnt;
  logic       filt_long;
  logic       filt_release;
  logic       nxt_filt_latch;
  logic       edge_rise;
  logic       edge_clear;
  logic       nxt_parity;
  logic       spur_now;
  logic [4:0] events;
  logic [7:0] rd_mux;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign wr_ctrl    = reg_wr && reg_addr == bia_pkg::ADR_CTRL;
  assign wr_eoi     = reg_wr && reg_addr == bia_pkg::ADR_EOI;
  assign wr_par_clr = reg_wr && reg_addr == bia_pkg::ADR_PAR_CLR;
  assign rd_stat    = reg_rd && reg_addr == bia_pkg::ADR_IRQ_STAT;

  // ****************************************************************
  // Cascaded controllers
  // ****************************************************************
  // Secondary output replaces the request on the cascade line
  assign pri_req = (pri_req_in & ~(8'h01 << CASCADE_LINE))
                 | ({7'h00, sec_int} << CASCADE_LINE);
  // Cascade line in the primary hands the acknowledge on
  assign sec_ack = cpu_int_ack && !pri_none && pri_lvl == CASCADE_LINE;

  bia_priority_int_ctrl u_pri (
    .clk       (clk),
    .rst_n     (rst_n),
    .req       (pri_req),
    .imask     (pri_mask_ff),
    .rotate    (ctrl_ff.rot_pri),
    .ack       (cpu_int_ack),
    .eoi       (wr_eoi && reg_wdata[bia_pkg::EOI_PRI_BIT]),
    .pend      (pri_pend),
    .insvc     (pri_insvc),
    .int_req   (pri_int),
    .ack_level (pri_lvl),
    .ack_none  (pri_none)
  );

  bia_priority_int_ctrl u_sec (
    .clk       (clk),
    .rst_n     (rst_n),
    .req       (sec_req_in),
    .imask     (sec_mask_ff),
    .rotate    (ctrl_ff.rot_sec),
    .ack       (sec_ack),
    .eoi       (wr_eoi && reg_wdata[bia_pkg::EOI_SEC_BIT]),
    .pend      (sec_pend),
    .insvc     (sec_insvc),
    .int_req   (sec_int),
    .ack_level (sec_lvl),
    .ack_none  (sec_none)
  );

  // Line 7 with nothing wired to it can only be spurious
  assign spur_now = sec_ack ? (sec_none || (sec_lvl == 3'h7 && ctrl_ff.ir7_tied))
                            : (pri_none || (pri_lvl == 3'h7 && ctrl_ff.ir7_tied));

  // ****************************************************************
  // Request filter
  // ****************************************************************
  assign raw_cpu_int_request = pri_int;
  assign nxt_filt_cnt = !raw_cpu_int_request ? 3'h0
                      : (filt_cnt_ff == bia_pkg::FILT_CYC) ? filt_cnt_ff
                      : 3'(filt_cnt_ff + 3'h1);
  assign filt_long    = raw_cpu_int_request && nxt_filt_cnt == bia_pkg::FILT_CYC;
  assign filt_release = ack_seen_ff && !raw_cpu_int_request;
  assign nxt_filt_latch = ctrl_ff.filt_en && !filt_release && (filt_latch_ff || filt_long);

  // ****************************************************************
  // NMI path, spare latch
  // ****************************************************************
  assign nonmaskable_request_in = backplane_int0 | parity_ff;
  assign nxt_parity = parity_err_pulse || (parity_ff && !wr_par_clr);
  assign nxt_nmi    = nonmaskable_request_in && !ctrl_ff.nmi_mask_bit;
  assign edge_rise  = edge_latch_set_in && !edge_in_prev_ff;
  assign edge_clear = !ctrl_ff.edge_clr_n;

  // ****************************************************************
  // Events and read data
  // ****************************************************************
  assign events[bia_pkg::EV_NMI]    = nxt_nmi && !nmi_prev_ff;
  assign events[bia_pkg::EV_REJECT] = ctrl_ff.filt_en && raw_prev_ff && !raw_cpu_int_request
                                    && filt_cnt_ff < bia_pkg::FILT_CYC;
  assign events[bia_pkg::EV_SPUR]   = cpu_int_ack && spur_now;
  assign events[bia_pkg::EV_EDGE]   = edge_rise;
  assign events[bia_pkg::EV_PARITY] = parity_err_pulse && !parity_ff;

  always_comb begin
    unique case (reg_addr)
      bia_pkg::ADR_CTRL:      rd_mux = ctrl_ff;
      bia_pkg::ADR_PRI_PEND:  rd_mux = pri_pend;
      bia_pkg::ADR_PRI_INSVC: rd_mux = pri_insvc;
      bia_pkg::ADR_PRI_MASK:  rd_mux = pri_mask_ff;
      bia_pkg::ADR_SEC_PEND:  rd_mux = sec_pend;
      bia_pkg::ADR_SEC_INSVC: rd_mux = sec_insvc;
      bia_pkg::ADR_SEC_MASK:  rd_mux = sec_mask_ff;
      bia_pkg::ADR_IRQ_STAT:  rd_mux = {3'h0, stat_ff};
      bia_pkg::ADR_IRQ_MASK:  rd_mux = {3'h0, imsk_ff};
      bia_pkg::ADR_STATE:     rd_mux = {cpu_int_ff, nmi_ff, filt_latch_ff, edge_ff,
                                        parity_ff, sec_int, pri_int, ack_seen_ff};
      default:                rd_mux = 8'h00;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff     <= bia_pkg::CTRL_RST;
      pri_mask_ff <= bia_pkg::PRIO_MASK_RST;
      sec_mask_ff <= bia_pkg::PRIO_MASK_RST;
      imsk_ff     <= 5'(bia_pkg::IRQ_MASK_RST);
      rdata_ff    <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_ff <= reg_wdata;
      if (reg_wr && reg_addr == bia_pkg::ADR_PRI_MASK) pri_mask_ff <= reg_wdata;
      if (reg_wr && reg_addr == bia_pkg::ADR_SEC_MASK) sec_mask_ff <= reg_wdata;
      if (reg_wr && reg_addr == bia_pkg::ADR_IRQ_MASK) imsk_ff <= reg_wdata[4:0];
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Set wins over the read-clear so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= 5'h00;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= (rd_stat ? 5'h00 : stat_ff) | events;
      irq_ff  <= |(((rd_stat ? 5'h00 : stat_ff) | events) & imsk_ff);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_cnt_ff   <= 3'h0;
      filt_latch_ff <= 1'b0;
      ack_seen_ff   <= 1'b0;
      raw_prev_ff   <= 1'b0;
      cpu_int_ff    <= 1'b0;
    end else begin
      filt_cnt_ff   <= nxt_filt_cnt;
      filt_latch_ff <= nxt_filt_latch;
      raw_prev_ff   <= raw_cpu_int_request;
      if (!nxt_filt_latch) ack_seen_ff <= 1'b0;
      else if (cpu_int_ack) ack_seen_ff <= 1'b1;
      // Filter off: plain pass-through, one register stage
      cpu_int_ff <= ctrl_ff.filt_en ? nxt_filt_latch : raw_cpu_int_request;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_ff          <= 1'b0;
      nmi_prev_ff     <= 1'b0;
      parity_ff       <= 1'b0;
      par_drive_n_ff  <= 1'b1;
      edge_ff         <= 1'b0;
      edge_in_prev_ff <= 1'b0;
      sec_route_ff    <= 1'b0;
    end else begin
      nmi_ff          <= nxt_nmi;
      nmi_prev_ff     <= nxt_nmi;
      parity_ff       <= nxt_parity;
      par_drive_n_ff  <= !nxt_parity;
      edge_in_prev_ff <= edge_latch_set_in;
      edge_ff         <= edge_rise || (edge_ff && !edge_clear);
      sec_route_ff    <= sec_int;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackv_ff <= 1'b0;
      vec_ff  <= '0;
      spur_ff <= 1'b0;
    end else begin
      ackv_ff <= cpu_int_ack;
      spur_ff <= cpu_int_ack && spur_now;
      if (cpu_int_ack) vec_ff <= sec_ack ? {1'b1, sec_lvl} : {1'b0, pri_lvl};
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata                 = rdata_ff;
  assign cpu_int_out               = cpu_int_ff;
  assign cpu_nmi_out               = nmi_ff;
  assign ack_valid                 = ackv_ff;
  assign ack_vector                = vec_ff;
  assign ack_spurious              = spur_ff;
  assign sec_int_route             = sec_route_ff;
  assign edge_latch_out            = edge_ff;
  assign parity_error_drive_n      = par_drive_n_ff;
  assign backplane_int_drive_one_n = ctrl_ff.bd1_n;
  assign backplane_int_drive_two_n = ctrl_ff.bd2_n;
  assign irq                       = irq_ff;
endmodule : bia_top

// ==== bia_pkg.sv ====
// Package: register map, constants and types of the board interrupt aggregator
package bia_pkg;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int         ADDR_W        = 4;
  localparam int         DATA_W        = 8;
  localparam logic [3:0] ADR_CTRL      = 4'h0;
  localparam logic [3:0] ADR_PRI_PEND  = 4'h1;
  localparam logic [3:0] ADR_PRI_INSVC = 4'h2;
  localparam logic [3:0] ADR_PRI_MASK  = 4'h3;
  localparam logic [3:0] ADR_SEC_PEND  = 4'h4;
  localparam logic [3:0] ADR_SEC_INSVC = 4'h5;
  localparam logic [3:0] ADR_SEC_MASK  = 4'h6;
  localparam logic [3:0] ADR_EOI       = 4'h7;
  localparam logic [3:0] ADR_PAR_CLR   = 4'h8;
  localparam logic [3:0] ADR_IRQ_STAT  = 4'h9;
  localparam logic [3:0] ADR_IRQ_MASK  = 4'hA;
  localparam logic [3:0] ADR_STATE     = 4'hB;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_RST      = 8'h1C;
  localparam logic [7:0] PRIO_MASK_RST = 8'hFF;
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int EOI_PRI_BIT = 0;
  localparam int EOI_SEC_BIT = 1;
  localparam int EV_NMI      = 0;
  localparam int EV_REJECT   = 1;
  localparam int EV_SPUR     = 2;
  localparam int EV_EDGE     = 3;
  localparam int EV_PARITY   = 4;
  localparam int N_EV        = 5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         CLK_MHZ  = 25;
  localparam int         FILT_NS  = 50;
  // Least time, so round up to whole cycles
  localparam int         FILT_INT = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] FILT_CYC = 3'(FILT_INT);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic ir7_tied;
    logic rot_sec;
    logic rot_pri;
    logic bd2_n;
    logic bd1_n;
    logic edge_clr_n;
    logic nmi_mask_bit;
    logic filt_en;
  } bia_ctrl_type;

  typedef struct packed {
    logic       sec;
    logic [2:0] level;
  } bia_vec_type;

endpackage : bia_pkg

// ==== bia_top_sva.sv ====
// Checker: port-level assertions of the board interrupt aggregator
`timescale 1ns/1ps

module bia_top_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       cpu_int_ack,
  input wire logic       backplane_int0,
  input wire logic       parity_err_pulse,
  input wire logic       edge_latch_set_in,
  input wire logic       cpu_int_out,
  input wire logic       cpu_nmi_out,
  input wire logic       ack_valid,
  input wire logic [3:0] ack_vector,
  input wire logic       ack_spurious,
  input wire logic       edge_latch_out,
  input wire logic       parity_error_drive_n,
  input wire logic       backplane_int_drive_one_n
);
  // ****************************************************************
  // Shadow of the control register
  // ****************************************************************
  bia_pkg::bia_ctrl_type ctrl_ff;
  bia_pkg::bia_ctrl_type nxt_ctrl;
  logic                  ack_seen_ff;
  logic                  nxt_ack_seen;

  assign nxt_ctrl = (reg_wr && reg_addr == bia_pkg::ADR_CTRL) ? bia_pkg::bia_ctrl_type'(reg_wdata) : ctrl_ff;
  // Remembers an acknowledge taken while the request stood
  assign nxt_ack_seen = cpu_int_out && (ack_seen_ff || cpu_int_ack);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff     <= bia_pkg::bia_ctrl_type'(bia_pkg::CTRL_RST);
      ack_seen_ff <= 1'b0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      ack_seen_ff <= nxt_ack_seen;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_nmi_masked: assert property ($past(ctrl_ff.nmi_mask_bit) |-> !cpu_nmi_out)
    else $error("NMI output high while masked");
  a_nmi_follows: assert property (!$past(ctrl_ff.nmi_mask_bit) && $past(backplane_int0) |-> cpu_nmi_out)
    else $error("NMI output missed backplane request");
  a_filt_hold: assert property (ctrl_ff.filt_en && $past(ctrl_ff.filt_en, 2) && $fell(cpu_int_out)
                                |-> $past(ack_seen_ff))
    else $error("Filtered request released without acknowledge");
  a_ack_answer: assert property (cpu_int_ack |=> ack_valid ##1 !ack_valid)
    else $error("Acknowledge answer pulse wrong");
  a_vec_hold: assert property (!$past(cpu_int_ack) |-> $stable(ack_vector))
    else $error("Vector changed without acknowledge");
  a_spur_level: assert property (ack_spurious |-> ack_valid && ack_vector[2:0] == 3'h7)
    else $error("Spurious answer not on level seven");
  a_edge_set: assert property ($rose(edge_latch_set_in) |-> ##[1:2] edge_latch_out)
    else $error("Spare latch missed rising edge");
  a_edge_clear: assert property ($past(!ctrl_ff.edge_clr_n) && !$past(edge_latch_set_in)
                                 && !$past(edge_latch_set_in, 2) |-> !edge_latch_out)
    else $error("Spare latch not cleared");
  a_parity_drive: assert property (parity_err_pulse |-> ##[1:2] !parity_error_drive_n)
    else $error("Parity drive not asserted");
  a_bus_drive: assert property ($past(ctrl_ff.bd1_n) == ctrl_ff.bd1_n
                                |-> backplane_int_drive_one_n == ctrl_ff.bd1_n)
    else $error("Backplane drive one differs from control");
endmodule : bia_top_sva

bind bia_top bia_top_sva chk_u (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .cpu_int_ack(cpu_int_ack), .backplane_int0(backplane_int0), .parity_err_pulse(parity_err_pulse),
  .edge_latch_set_in(edge_latch_set_in), .cpu_int_out(cpu_int_out), .cpu_nmi_out(cpu_nmi_out),
  .ack_valid(ack_valid), .ack_vector(ack_vector), .ack_spurious(ack_spurious),
  .edge_latch_out(edge_latch_out), .parity_error_drive_n(parity_error_drive_n),
  .backplane_int_drive_one_n(backplane_int_drive_one_n)
);

// ==== bia_cpu_model.sv ====
// Partner model: processor core running acknowledge cycles
`timescale 1ns/1ps

module bia_cpu_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cpu_int_out,
  input  wire logic ack_en,
  input  wire logic slow,
  input  wire logic force_ack,
  output logic      cpu_int_ack
);
  initial cpu_int_ack = 1'b0;

  always begin
    @(posedge clk);
    if (rst_n && ((ack_en && cpu_int_out) || force_ack)) begin
      // Late core: the request may be gone by the time it answers
      if (slow) begin
        repeat (4) @(posedge clk);
      end
      cpu_int_ack <= 1'b1;
      @(posedge clk);
      cpu_int_ack <= 1'b0;
      // Let the in-service bit drop the request before looking again
      repeat (4) @(posedge clk);
    end
  end
endmodule : bia_cpu_model

// ==== bia_top_tb.sv ====
// Testbench: register, controller, filter, NMI and latch scenarios
`timescale 1ns/1ps

module bia_top_tb;
  logic       clk, rst_n, reg_wr, reg_rd, cpu_int_ack, bp0, par, eset;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pri_req, sec_req, d;
  logic       cpu_int_out, cpu_nmi_out, ack_valid, ack_spurious, sec_int_route, edge_latch_out;
  logic       par_n, bd1_n, bd2_n, irq, ack_en, slow, force_ack, got_spur;
  logic [3:0] ack_vector, got_vec;
  int         n_fail = 0;
  int         n_tests = 0;
  logic [3:0] ra [5] = '{bia_pkg::ADR_CTRL, bia_pkg::ADR_PRI_MASK, bia_pkg::ADR_SEC_MASK,
                         bia_pkg::ADR_IRQ_MASK, 4'hC};
  logic [7:0] rv [5] = '{bia_pkg::CTRL_RST, 8'hFF, 8'hFF, 8'h00, 8'h00};

  bia_top dut_u (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pri_req_in(pri_req), .sec_req_in(sec_req),
    .cpu_int_ack(cpu_int_ack), .backplane_int0(bp0), .parity_err_pulse(par), .edge_latch_set_in(eset),
    .cpu_int_out(cpu_int_out), .cpu_nmi_out(cpu_nmi_out), .ack_valid(ack_valid), .ack_vector(ack_vector),
    .ack_spurious(ack_spurious), .sec_int_route(sec_int_route), .edge_latch_out(edge_latch_out),
    .parity_error_drive_n(par_n), .backplane_int_drive_one_n(bd1_n),
    .backplane_int_drive_two_n(bd2_n), .irq(irq)
  );

  bia_cpu_model cpu_u (
    .clk(clk), .rst_n(rst_n), .cpu_int_out(cpu_int_out), .ack_en(ack_en), .slow(slow),
    .force_ack(force_ack), .cpu_int_ack(cpu_int_ack)
  );

  always #20 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd

  task automatic wait_ack;
    int i;
    for (i = 0; i < 60 && ack_valid !== 1'b1; i++) @(negedge clk);
    check({7'h00, ack_valid}, 8'h01);
    got_vec  = ack_vector;
    got_spur = ack_spurious;
    @(negedge clk);
  endtask : wait_ack

  task automatic conclude;
    $display("Comparisons: %0d, mismatches: %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {clk, rst_n, reg_wr, reg_rd, bp0, par, eset, ack_en, slow, force_ack} = '0;
    {reg_addr, reg_wdata, pri_req, sec_req} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[k]) begin
      rd(ra[k], d);
      check(d, rv[k]);
    end
    wr(bia_pkg::ADR_PRI_MASK, 8'h00);
    wr(bia_pkg::ADR_SEC_MASK, 8'h00);
    wr(bia_pkg::ADR_IRQ_MASK, 8'h1F);
    @(posedge clk) pri_req <= 8'h24;
    tick(3);
    check({7'h00, cpu_int_out}, 8'h01);
    rd(bia_pkg::ADR_PRI_PEND, d);
    check(d, 8'h24);
    @(posedge clk) ack_en <= 1'b1;
    wait_ack();
    check({4'h0, got_vec}, 8'h02);
    rd(bia_pkg::ADR_PRI_INSVC, d);
    check(d, 8'h04);
    @(posedge clk) pri_req <= 8'h20;
    wr(bia_pkg::ADR_EOI, 8'h01);
    wait_ack();
    check({4'h0, got_vec}, 8'h05);
    // Serial source left on line 6 as a plain primary line
    @(posedge clk) pri_req <= 8'h40;
    wr(bia_pkg::ADR_EOI, 8'h01);
    wait_ack();
    check({4'h0, got_vec}, 8'h06);
    @(posedge clk) pri_req <= 8'h00;
    wr(bia_pkg::ADR_EOI, 8'h01);
    // Cascade with a late core
    @(posedge clk) sec_req <= 8'h08;
    slow <= 1'b1;
    tick(3);
    check({7'h00, sec_int_route}, 8'h01);
    wait_ack();
    check({4'h0, got_vec}, 8'h0B);
    @(posedge clk) sec_req <= 8'h00;
    slow <= 1'b0;
    wr(bia_pkg::ADR_EOI, 8'h03);
    // Rotation hands the next turn to line 1, then back to line 0
    wr(bia_pkg::ADR_CTRL, 8'h3C);
    @(posedge clk) pri_req <= 8'h03;
    wait_ack();
    check({4'h0, got_vec}, 8'h00);
    wr(bia_pkg::ADR_EOI, 8'h01);
    wait_ack();
    check({4'h0, got_vec}, 8'h01);
    wr(bia_pkg::ADR_EOI, 8'h01);
    wait_ack();
    check({4'h0, got_vec}, 8'h00);
    @(posedge clk) pri_req <= 8'h00;
    wr(bia_pkg::ADR_EOI, 8'h01);
    wr(bia_pkg::ADR_CTRL, 8'h1C);
    // Acknowledge with nothing pending
    @(posedge clk) force_ack <= 1'b1;
    @(posedge clk) force_ack <= 1'b0;
    wait_ack();
    check({4'h0, got_spur, got_vec[2:0]}, 8'h0F);
    rd(bia_pkg::ADR_IRQ_STAT, d);
    check(d & 8'h04, 8'h04);
    // NMI gate and interrupt status
    @(posedge clk) bp0 <= 1'b1;
    tick(3);
    check({7'h00, cpu_nmi_out}, 8'h01);
    wr(bia_pkg::ADR_CTRL, 8'h1E);
    tick(2);
    check({7'h00, cpu_nmi_out}, 8'h00);
    wr(bia_pkg::ADR_CTRL, 8'h1C);
    @(posedge clk) bp0 <= 1'b0;
    rd(bia_pkg::ADR_IRQ_STAT, d);
    @(posedge clk) par <= 1'b1;
    @(posedge clk) par <= 1'b0;
    tick(3);
    check({7'h00, cpu_nmi_out}, 8'h01);
    check({7'h00, par_n}, 8'h00);
    check({7'h00, irq}, 8'h01);
    wr(bia_pkg::ADR_IRQ_MASK, 8'h00);
    tick(2);
    check({7'h00, irq}, 8'h00);
    wr(bia_pkg::ADR_IRQ_MASK, 8'h1F);
    rd(bia_pkg::ADR_IRQ_STAT, d);
    check(d, 8'h11);
    tick(2);
    check({7'h00, irq}, 8'h00);
    wr(bia_pkg::ADR_PAR_CLR, 8'h00);
    tick(3);
    check({7'h00, cpu_nmi_out}, 8'h00);
    // Request filter: short pulse rejected, long request held
    @(posedge clk) ack_en <= 1'b0;
    wr(bia_pkg::ADR_CTRL, 8'h1D);
    @(posedge clk) pri_req <= 8'h02;
    @(posedge clk) pri_req <= 8'h00;
    tick(6);
    check({7'h00, cpu_int_out}, 8'h00);
    rd(bia_pkg::ADR_IRQ_STAT, d);
    check(d, 8'h02);
    @(posedge clk) pri_req <= 8'h02;
    tick(4);
    @(posedge clk) pri_req <= 8'h00;
    tick(6);
    check({7'h00, cpu_int_out}, 8'h01);
    @(posedge clk) ack_en <= 1'b1;
    wait_ack();
    tick(4);
    check({7'h00, cpu_int_out}, 8'h00);
    wr(bia_pkg::ADR_CTRL, 8'h1C);
    // Spare latch and backplane drives
    @(posedge clk) eset <= 1'b1;
    @(posedge clk) eset <= 1'b0;
    tick(4);
    check({7'h00, edge_latch_out}, 8'h01);
    wr(bia_pkg::ADR_CTRL, 8'h18);
    tick(2);
    check({7'h00, edge_latch_out}, 8'h00);
    wr(bia_pkg::ADR_CTRL, 8'h04);
    tick(2);
    check({6'h00, bd2_n, bd1_n}, 8'h00);
    wr(bia_pkg::ADR_CTRL, 8'h1C);
    tick(2);
    check({6'h00, bd2_n, bd1_n}, 8'h03);
    conclude();
  end
endmodule : bia_top_tb
